// >>> hw/pff_pkg.sv
package pff_pkg;

    // Predicate width: one bit per vector byte (256-bit vector)
    localparam int PRED_W = 32;
    localparam int SCALAR_W = 64;
    localparam int RES_W_W = 7;

    // Element size codes
    typedef enum logic [1:0] {
        PFF_ESZ_B,
        PFF_ESZ_H,
        PFF_ESZ_S,
        PFF_ESZ_D
    } pff_esz_t;

    // Issued operation
    typedef enum logic [2:0] {
        PFF_OP_NONE,
        PFF_OP_SET_ALL,
        PFF_OP_READ,
        PFF_OP_READ_FLAGS,
        PFF_OP_WRITE,
        PFF_OP_PTEST,
        PFF_OP_PRED_FLAGS,
        PFF_OP_CTERM
    } pff_op_t;

    // Flag bit positions in the flag word
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [PRED_W-1:0] FAULT_MASK_RESET = {PRED_W{1'b1}};

    // Issue request
    typedef struct packed {
        logic valid;
        pff_op_t op;
        pff_esz_t esz;
        logic predicated;
        logic [PRED_W-1:0] gov;
        logic [PRED_W-1:0] src;
        logic cterm_n;
        logic cterm_v;
    } pff_issue_t;

    // Load unit fault report
    typedef struct packed {
        logic valid;
        logic failed;
        logic [4:0] elem;
        pff_esz_t esz;
    } pff_fault_t;

    // Scalar result to be widened
    typedef struct packed {
        logic valid;
        logic [RES_W_W-1:0] width;
        logic [SCALAR_W-1:0] data;
    } pff_scalar_t;

    // Condition tests computed from the flags
    typedef struct packed {
        logic more_active;
        logic last_or_none;
        logic not_last;
        logic not_first;
        logic term_continue;
        logic term_detected;
    } pff_cond_t;

endpackage

// >>> hw/pff_flag_eval.sv
`timescale 1ns/1ps
module pff_flag_eval
    import pff_pkg::*;
#(
    parameter int W = PRED_W
)
(
    // Inputs
    input wire logic [W-1:0] gov,
    input wire logic [W-1:0] src,
    input wire logic predicated,
    input wire pff_pkg::pff_esz_t esz,
    // Flags
    output logic flag_n,
    output logic flag_z,
    output logic flag_c
);
    logic [W-1:0] sel;
    logic [W-1:0] act;
    logic seen;
    logic last_val;

    // Only the lowest bit of each element group counts
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            unique case (esz)
                PFF_ESZ_B: sel[i] = 1'b1;
                PFF_ESZ_H: sel[i] = (i % 2) == 0;
                PFF_ESZ_S: sel[i] = (i % 4) == 0;
                PFF_ESZ_D: sel[i] = (i % 8) == 0;
            endcase
        end
    end

    assign act = sel & (predicated ? gov : {W{1'b1}});

    // First and last active element scan
    always_comb
    begin
        flag_n = 1'b0;
        flag_z = 1'b1;
        last_val = 1'b0;
        seen = 1'b0;
        for (int i = 0; i < W; i++)
        begin
            if (act[i])
            begin
                if (!seen)
                begin
                    flag_n = src[i];
                end
                seen = 1'b1;
                last_val = src[i];
                if (src[i])
                begin
                    flag_z = 1'b0;
                end
            end
        end
        flag_c = ~last_val;
    end

    initial
    begin
        if (W % 8 != 0)
        begin
            $error("pff_flag_eval: width must be a multiple of 8");
        end
    end
endmodule

// >>> hw/pff_core.sv
`timescale 1ns/1ps
module pff_core
    import pff_pkg::*;
#(
    parameter int W = PRED_W,
    parameter int SW = SCALAR_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Issue side
    input wire pff_pkg::pff_issue_t issue,
    input wire pff_pkg::pff_fault_t fault,
    input wire pff_pkg::pff_scalar_t scalar_in,
    input wire logic [W-1:0] write_data,
    // Results
    output logic [W-1:0] fault_mask_reg,
    output logic [W-1:0] read_data_reg,
    output logic read_valid_reg,
    output logic [3:0] process_state_flags,
    output logic flags_valid_reg,
    output pff_pkg::pff_cond_t cond_reg,
    output logic [SW-1:0] scalar_out_reg,
    output logic scalar_valid_reg
);
    import pff_pkg::*;

    logic [W-1:0] mask_next;
    logic [W-1:0] mask_fwd;
    logic [W-1:0] kill;
    logic [W-1:0] rd_next;
    logic rv_next;
    logic [3:0] flags_reg;
    logic [3:0] flags_next;
    logic fv_next;
    pff_cond_t cond_next;
    logic [SW-1:0] sc_next;
    logic sv_next;
    logic [W-1:0] ev_src;
    logic [W-1:0] ev_gov;
    logic ev_pred;
    logic fn;
    logic fz;
    logic fc;
    int first_byte;

    // Fault kill vector: failed element and everything above it
    always_comb
    begin
        kill = '0;
        first_byte = 0;
        unique case (fault.esz)
            PFF_ESZ_B: first_byte = int'(fault.elem);
            PFF_ESZ_H: first_byte = int'(fault.elem) * 2;
            PFF_ESZ_S: first_byte = int'(fault.elem) * 4;
            PFF_ESZ_D: first_byte = int'(fault.elem) * 8;
        endcase
        if (fault.valid && fault.failed)
        begin
            for (int i = 0; i < W; i++)
            begin
                kill[i] = (i >= first_byte);
            end
        end
    end

    // Load faults only clear bits; only set-all and write can raise mask bits
    always_comb
    begin
        mask_next = fault_mask_reg & ~kill;
        if (issue.valid && issue.op == PFF_OP_SET_ALL)
        begin
            mask_next = {W{1'b1}} & ~kill;
        end
        else if (issue.valid && issue.op == PFF_OP_WRITE)
        begin
            mask_next = write_data & ~kill;
        end
    end

    // Same-cycle faults are older than the read, so forward them
    assign mask_fwd = fault_mask_reg & ~kill;

    // Source selection for flag evaluation
    always_comb
    begin
        ev_src = issue.src;
        ev_gov = issue.gov;
        ev_pred = issue.predicated;
        if (issue.op == PFF_OP_READ_FLAGS)
        begin
            ev_src = mask_fwd & (issue.predicated ? issue.gov : {W{1'b1}});
        end
    end

    pff_flag_eval #(
        .W(W)
    ) u_eval (
        .gov(ev_gov),
        .src(ev_src),
        .predicated(ev_pred),
        .esz(issue.esz),
        .flag_n(fn),
        .flag_z(fz),
        .flag_c(fc)
    );

    // Reads of the mask and flag updates
    always_comb
    begin
        rd_next = read_data_reg;
        rv_next = 1'b0;
        flags_next = flags_reg;
        fv_next = 1'b0;
        if (issue.valid)
        begin
            unique case (issue.op)
                PFF_OP_READ:
                begin
                    rd_next = issue.predicated ? (mask_fwd & issue.gov)
                                               : mask_fwd;
                    rv_next = 1'b1;
                end
                PFF_OP_READ_FLAGS:
                begin
                    rd_next = ev_src;
                    rv_next = 1'b1;
                    flags_next = {fn, fz, fc, 1'b0};
                    fv_next = 1'b1;
                end
                PFF_OP_PTEST, PFF_OP_PRED_FLAGS:
                begin
                    flags_next = {fn, fz, fc, 1'b0};
                    fv_next = 1'b1;
                end
                PFF_OP_CTERM:
                begin
                    // Compare-and-terminate reports its own N and V
                    flags_next = {issue.cterm_n, 1'b0, 1'b1,
                                  issue.cterm_v};
                    fv_next = 1'b1;
                end
                default:
                begin
                    rv_next = 1'b0;
                end
            endcase
        end
    end

    // Condition tests from the flags being written
    always_comb
    begin
        cond_next.more_active = flags_next[FLAG_C]
            & ~flags_next[FLAG_Z];
        cond_next.last_or_none = ~flags_next[FLAG_C]
            | flags_next[FLAG_Z];
        cond_next.not_last = flags_next[FLAG_C];
        cond_next.not_first = ~flags_next[FLAG_N];
        cond_next.term_continue = flags_next[FLAG_N]
            == flags_next[FLAG_V];
        cond_next.term_detected = flags_next[FLAG_N]
            != flags_next[FLAG_V];
    end

    // Zero-extension of narrow scalar results
    always_comb
    begin
        sc_next = scalar_out_reg;
        sv_next = scalar_in.valid;
        if (scalar_in.valid)
        begin
            for (int i = 0; i < SW; i++)
            begin
                sc_next[i] = (i < int'(scalar_in.width))
                    ? scalar_in.data[i] : 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fault_mask_reg <= FAULT_MASK_RESET;
            read_data_reg <= '0;
            read_valid_reg <= 1'b0;
            flags_reg <= FLAGS_RESET;
            flags_valid_reg <= 1'b0;
            cond_reg <= '0;
            scalar_out_reg <= '0;
            scalar_valid_reg <= 1'b0;
        end
        else
        begin
            fault_mask_reg <= mask_next;
            read_data_reg <= rd_next;
            read_valid_reg <= rv_next;
            flags_reg <= flags_next;
            flags_valid_reg <= fv_next;
            cond_reg <= cond_next;
            scalar_out_reg <= sc_next;
            scalar_valid_reg <= sv_next;
        end
    end

    assign process_state_flags = flags_reg;

    initial
    begin
        if (W % 8 != 0 || W > 256 || SW < 1)
        begin
            $error("pff_core: unsupported width");
        end
    end
endmodule

// >>> tb/pff_core_props.sv
`timescale 1ns/1ps
module pff_core_props
    import pff_pkg::*;
#(
    parameter int W = PRED_W,
    parameter int SW = SCALAR_W
)
(
    // Watched ports
    input wire logic clk,
    input wire logic rst_n,
    input wire pff_pkg::pff_issue_t issue,
    input wire pff_pkg::pff_fault_t fault,
    input wire pff_pkg::pff_scalar_t scalar_in,
    input wire logic [W-1:0] write_data,
    input wire logic [W-1:0] fault_mask_reg,
    input wire logic [W-1:0] read_data_reg,
    input wire logic read_valid_reg,
    input wire logic [3:0] process_state_flags,
    input wire logic flags_valid_reg,
    input wire pff_pkg::pff_cond_t cond_reg,
    input wire logic [SW-1:0] scalar_out_reg,
    input wire logic scalar_valid_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic kill;
    logic direct;
    logic [7:0] kpos;
    logic [3:0] f;
    assign kill = fault.valid && fault.failed;
    assign direct = issue.valid &&
        (issue.op == PFF_OP_SET_ALL || issue.op == PFF_OP_WRITE);
    assign kpos = {3'h0, fault.elem} << fault.esz;
    assign f = process_state_flags;
    sequence s_op(o);
        issue.valid && issue.op == o;
    endsequence
    property p_set;
        s_op(PFF_OP_SET_ALL) ##0 !kill |=> fault_mask_reg == '1;
    endproperty
    a_set: assert property (p_set) else $error("set-all lost");
    property p_kill;
        kill |=> (fault_mask_reg >> $past(kpos)) == '0;
    endproperty
    a_kill: assert property (p_kill) else $error("kill missed");
    property p_rise;
        !direct |=> (fault_mask_reg & ~$past(fault_mask_reg)) == '0;
    endproperty
    a_rise: assert property (p_rise) else $error("mask bit rose");
    property p_wr;
        s_op(PFF_OP_WRITE) ##0 !kill |=> fault_mask_reg == $past(write_data);
    endproperty
    a_wr: assert property (p_wr) else $error("write lost");
    property p_rd;
        s_op(PFF_OP_READ) ##0 !kill && !issue.predicated |=>
            read_valid_reg && read_data_reg == $past(fault_mask_reg);
    endproperty
    a_rd: assert property (p_rd) else $error("read wrong");
    property p_vclr;
        issue.valid && issue.op inside {PFF_OP_PTEST, PFF_OP_PRED_FLAGS,
            PFF_OP_READ_FLAGS} |=> flags_valid_reg && !f[FLAG_V];
    endproperty
    a_vclr: assert property (p_vclr) else $error("V not cleared");
    property p_cond;
        flags_valid_reg |-> cond_reg.term_detected == (f[FLAG_N] != f[FLAG_V])
            && cond_reg.more_active == (f[FLAG_C] && !f[FLAG_Z]);
    endproperty
    a_cond: assert property (p_cond) else $error("cond wrong");
    property p_zext;
        scalar_in.valid |=> scalar_valid_reg &&
            (scalar_out_reg >> $past(scalar_in.width)) == '0;
    endproperty
    a_zext: assert property (p_zext) else $error("no zero ext");
endmodule

bind pff_core pff_core_props #(.W(W), .SW(SW)) u_props (.clk(clk),
    .rst_n(rst_n), .issue(issue), .fault(fault), .scalar_in(scalar_in),
    .write_data(write_data), .fault_mask_reg(fault_mask_reg),
    .read_data_reg(read_data_reg), .read_valid_reg(read_valid_reg),
    .process_state_flags(process_state_flags),
    .flags_valid_reg(flags_valid_reg), .cond_reg(cond_reg),
    .scalar_out_reg(scalar_out_reg), .scalar_valid_reg(scalar_valid_reg));

// >>> tb/pff_far_model.sv
`timescale 1ns/1ps
module pff_far_model
    import pff_pkg::*;
(
    // Clock
    input wire logic clk,
    // Requests
    output pff_pkg::pff_issue_t issue,
    output pff_pkg::pff_fault_t fault,
    output pff_pkg::pff_scalar_t scalar_in,
    output logic [PRED_W-1:0] write_data
);
    initial
    begin
        issue = '0;
        fault = '0;
        scalar_in = '0;
        write_data = '0;
    end
    // Stale gov and write data are inverted so nothing can lean on them
    task automatic step(pff_issue_t i, pff_fault_t f, pff_scalar_t s,
        logic [PRED_W-1:0] w);
        @(negedge clk);
        issue = i;
        fault = f;
        scalar_in = s;
        write_data = w;
        @(negedge clk);
        issue.valid = 1'b0;
        issue.gov = ~issue.gov;
        fault.valid = 1'b0;
        scalar_in.valid = 1'b0;
        write_data = ~write_data;
    endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
    import pff_pkg::*;
    logic clk;
    logic rst_n;
    pff_issue_t issue;
    pff_fault_t fault;
    pff_scalar_t scalar_in;
    logic [PRED_W-1:0] wd;
    logic [PRED_W-1:0] mask;
    logic [PRED_W-1:0] rd;
    logic rd_v;
    logic [3:0] flags;
    logic fl_v;
    logic [SCALAR_W-1:0] so;
    logic so_v;
    int err_count;
    int n_compared;
    pff_far_model u_far (.clk(clk), .issue(issue), .fault(fault),
        .scalar_in(scalar_in), .write_data(wd));
    pff_core u_dut (.clk(clk), .rst_n(rst_n), .issue(issue),
        .fault(fault), .scalar_in(scalar_in), .write_data(wd),
        .fault_mask_reg(mask), .read_data_reg(rd), .read_valid_reg(rd_v),
        .process_state_flags(flags), .flags_valid_reg(fl_v),
        .cond_reg(), .scalar_out_reg(so), .scalar_valid_reg(so_v));
    function automatic pff_issue_t mk(pff_op_t o, pff_esz_t e = PFF_ESZ_B,
        logic p = 0, logic [31:0] g = 0, logic [31:0] s = 0,
        logic n = 0, logic v = 1);
        mk = {1'b1, o, e, p, g, s, n, v};
    endfunction
    function automatic pff_fault_t fl(logic [4:0] el, pff_esz_t e, logic f);
        fl = {1'b1, f, el, e};
    endfunction
    task automatic chk(string nm, logic [71:0] seen, logic [71:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic io(pff_issue_t i, pff_fault_t f, logic [31:0] w);
        u_far.step(i, f, '0, w);
    endtask
    task automatic ft(pff_op_t o, pff_esz_t e, logic p, logic [31:0] g,
        logic [31:0] s, logic n, logic v, logic [3:0] x);
        io(mk(o, e, p, g, s, n, v), '0, 0);
        chk("flags", {fl_v, flags}, {1'b1, x});
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        repeat (2000) @(posedge clk);
        err_count++;
        stop_test();
    end
    initial
    begin
        err_count = 0;
        n_compared = 0;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        chk("reset", {mask, flags}, {32'hFFFF_FFFF, 4'h0});
        io('0, fl(5'd5, PFF_ESZ_B, 1), 0);
        chk("kill", mask, 32'h1F);
        io('0, fl(5'd10, PFF_ESZ_B, 1), 0);
        chk("no rise", mask, 32'h1F);
        io('0, fl(5'd1, PFF_ESZ_H, 1), 0);
        chk("kill h", mask, 32'h3);
        io('0, fl(5'd0, PFF_ESZ_B, 0), 0);
        chk("good load", mask, 32'h3);
        io(mk(PFF_OP_READ), '0, 0);
        chk("read", {rd_v, rd}, {1'b1, 32'h3});
        io(mk(PFF_OP_READ_FLAGS), '0, 0);
        chk("rdf", {fl_v, flags, rd}, {1'b1, 4'hA, 32'h3});
        io(mk(PFF_OP_SET_ALL), '0, 0);
        chk("set", mask, 32'hFFFF_FFFF);
        io(mk(PFF_OP_SET_ALL), fl(5'd4, PFF_ESZ_B, 1), 0);
        chk("set kill", mask, 32'hF);
        io(mk(PFF_OP_WRITE), '0, 32'hA5);
        chk("write", mask, 32'hA5);
        io(mk(PFF_OP_READ), fl(5'd2, PFF_ESZ_B, 1), 0);
        chk("read kill", {rd, mask}, {32'h1, 32'h1});
        ft(PFF_OP_PTEST, PFF_ESZ_H, 1, 32'hABFE, 32'hBBFA, 0, 1, 4'h0);
        ft(PFF_OP_PTEST, PFF_ESZ_H, 0, 0, 32'hBBFA, 0, 1, 4'h2);
        ft(PFF_OP_PRED_FLAGS, PFF_ESZ_B, 1, '1, 0, 0, 1, 4'h6);
        ft(PFF_OP_PTEST, PFF_ESZ_D, 0, 0, 32'h01FE_0001, 0, 1, 4'h8);
        ft(PFF_OP_CTERM, PFF_ESZ_B, 0, 0, 0, 1, 0, 4'hA);
        ft(PFF_OP_CTERM, PFF_ESZ_B, 0, 0, 0, 1, 1, 4'hB);
        u_far.step('0, '0, {1'b1, 7'd8, 64'hFFFF_FFFF_FFFF_FFFF}, 0);
        chk("zext", {so_v, so}, {1'b1, 64'hFF});
        u_far.step('0, '0, {1'b1, 7'd64, 64'hFFFF_FFFF_FFFF_FFFF}, 0);
        chk("full", so, 64'hFFFF_FFFF_FFFF_FFFF);
        stop_test();
    end
endmodule
